/* include/phyirq_pkg.sv */
`default_nettype none
package phyirq_pkg;
    localparam int          REG_AW            = 5;
    localparam int          REG_DW            = 16;
    localparam int          EVENT_COUNT       = 8;
    localparam logic [4:0]  ADDR_EVENT_IRQ    = 5'h1B;
    localparam logic [4:0]  ADDR_LED_LINE     = 5'h1E;
    localparam logic [4:0]  ADDR_CROSSOVER    = 5'h1F;
    localparam int          EVT_ENABLE_LSB    = 8;
    localparam int          EVT_STATUS_LSB    = 0;
    localparam int          LED_MAP_LSB       = 14;
    localparam int          POLARITY_BIT      = 13;
    localparam int          PAIR_STATE_BIT    = 11;
    localparam int          REMOTE_LOOP_BIT   = 7;
    localparam int          XALG_BIT          = 15;
    localparam int          MANUAL_X_BIT      = 14;
    localparam int          SWAP_DISABLE_BIT  = 13;
    localparam int          IRQ_LEVEL_BIT     = 9;
    localparam logic [7:0]  EVT_ENABLE_RESET  = 8'h00;
    localparam logic [7:0]  EVT_STATUS_RESET  = 8'h00;
    localparam logic [1:0]  LED_MAP_RESET     = 2'h0;
    localparam logic        REMOTE_LOOP_RESET = 1'b0;
    localparam logic        XALG_RESET        = 1'b1;
    localparam logic        MANUAL_X_RESET    = 1'b0;
    localparam logic        SWAP_DIS_RESET    = 1'b0;
    localparam logic        IRQ_LEVEL_RESET   = 1'b0;
    localparam logic [1:0]  LED_MAP_SPEED     = 2'h0;
    localparam logic [1:0]  LED_MAP_ACTIVITY  = 2'h1;
    localparam logic [15:0] ZERO_WORD         = 16'h0000;
endpackage : phyirq_pkg
`default_nettype wire

/* hdl/phyirq_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module phyirq_sync
    import phyirq_pkg::*;
#(
    parameter int WIDTH = 8
) (
    input  wire logic             clk_in,
    input  wire logic             rst_in,
    input  wire logic [WIDTH-1:0] async_in,
    output var  logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] stage1;

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            stage1   <= '0;
            sync_out <= '0;
        end else begin
            stage1   <= async_in;
            sync_out <= stage1;
        end
    end
endmodule : phyirq_sync
`default_nettype wire

/* hdl/phyirq_regs.sv */
`timescale 1ns/1ps
`default_nettype none
module phyirq_regs
    import phyirq_pkg::*;
#(
    parameter int NEVT = EVENT_COUNT
) (
    input  wire logic              clk_in,
    input  wire logic              rst_in,
    input  wire logic [REG_AW-1:0] reg_addr_in,
    input  wire logic              reg_wr_in,
    input  wire logic              reg_rd_in,
    input  wire logic [REG_DW-1:0] reg_wdata_in,
    output var  logic [REG_DW-1:0] reg_rdata_out,
    input  wire logic [NEVT-1:0]   event_pulse_in,
    input  wire logic              polarity_reversed_in,
    input  wire logic              auto_pair_crossed_in,
    input  wire logic              speed_ind_in,
    input  wire logic              link_ind_in,
    input  wire logic              activity_ind_in,
    output var  logic              irq_out,
    output var  logic [1:0]        led_out,
    output var  logic              remote_loopback_out,
    output var  logic              crossover_algorithm_select_out,
    output var  logic              auto_crossover_en_out,
    output var  logic              pair_crossed_out,
    output var  logic              tx_on_rx_pair_out
);
    logic [NEVT-1:0] evt_enable;
    logic [NEVT-1:0] evt_status;
    logic [NEVT-1:0] evt_sync;
    logic [NEVT-1:0] evt_prev;
    logic [NEVT-1:0] evt_rise;
    logic [1:0]      line_sync;
    logic [1:0]      indicator_map_select;
    logic            remote_loop;
    logic            crossover_algorithm_select;
    logic            manual_crossed;
    logic            swap_disable;
    logic            irq_level;
    logic            rd_event;
    logic            any_pending;

    // Events arrive from other domains; rising edges mark an occurrence
    phyirq_sync #(.WIDTH(NEVT)) u_evt_sync (
        .clk_in   (clk_in),
        .rst_in   (rst_in),
        .async_in (event_pulse_in),
        .sync_out (evt_sync)
    );

    phyirq_sync #(.WIDTH(2)) u_line_sync (
        .clk_in   (clk_in),
        .rst_in   (rst_in),
        .async_in ({polarity_reversed_in, auto_pair_crossed_in}),
        .sync_out (line_sync)
    );

    function automatic logic hit(input logic [REG_AW-1:0] a, input logic [REG_AW-1:0] b);
        return a == b;
    endfunction : hit

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            evt_prev <= '0;
        end else begin
            evt_prev <= evt_sync;
        end
    end

    assign evt_rise = evt_sync & ~evt_prev;
    assign rd_event = reg_rd_in && hit(reg_addr_in, ADDR_EVENT_IRQ);

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            evt_enable <= EVT_ENABLE_RESET;
        end else if (reg_wr_in && hit(reg_addr_in, ADDR_EVENT_IRQ)) begin
            evt_enable <= reg_wdata_in[EVT_ENABLE_LSB +: NEVT];
        end
    end

    // New event in the read cycle survives the clear
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            evt_status <= EVT_STATUS_RESET;
        end else if (rd_event) begin
            evt_status <= evt_rise;
        end else begin
            evt_status <= evt_status | evt_rise;
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            indicator_map_select <= LED_MAP_RESET;
            remote_loop          <= REMOTE_LOOP_RESET;
        end else if (reg_wr_in && hit(reg_addr_in, ADDR_LED_LINE)) begin
            indicator_map_select <= reg_wdata_in[LED_MAP_LSB +: 2];
            remote_loop          <= reg_wdata_in[REMOTE_LOOP_BIT];
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            crossover_algorithm_select <= XALG_RESET;
            manual_crossed             <= MANUAL_X_RESET;
            swap_disable               <= SWAP_DIS_RESET;
            irq_level                  <= IRQ_LEVEL_RESET;
        end else if (reg_wr_in && hit(reg_addr_in, ADDR_CROSSOVER)) begin
            crossover_algorithm_select <= reg_wdata_in[XALG_BIT];
            manual_crossed             <= reg_wdata_in[MANUAL_X_BIT];
            swap_disable               <= reg_wdata_in[SWAP_DISABLE_BIT];
            irq_level                  <= reg_wdata_in[IRQ_LEVEL_BIT];
        end
    end

    // Read data registered; only documented fields are placed, rest stays zero
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            reg_rdata_out <= ZERO_WORD;
        end else if (reg_rd_in) begin
            reg_rdata_out <= ZERO_WORD;
            if (hit(reg_addr_in, ADDR_EVENT_IRQ)) begin
                reg_rdata_out[EVT_ENABLE_LSB +: NEVT] <= evt_enable;
                reg_rdata_out[EVT_STATUS_LSB +: NEVT] <= evt_status;
            end else if (hit(reg_addr_in, ADDR_LED_LINE)) begin
                reg_rdata_out[LED_MAP_LSB +: 2]   <= indicator_map_select;
                reg_rdata_out[POLARITY_BIT]       <= line_sync[1];
                reg_rdata_out[PAIR_STATE_BIT]     <= pair_crossed_out;
                reg_rdata_out[REMOTE_LOOP_BIT]    <= remote_loop;
            end else if (hit(reg_addr_in, ADDR_CROSSOVER)) begin
                reg_rdata_out[XALG_BIT]         <= crossover_algorithm_select;
                reg_rdata_out[MANUAL_X_BIT]     <= manual_crossed;
                reg_rdata_out[SWAP_DISABLE_BIT] <= swap_disable;
                reg_rdata_out[IRQ_LEVEL_BIT]    <= irq_level;
            end
        end
    end

    assign any_pending = |(evt_status & evt_enable);

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            irq_out <= ~IRQ_LEVEL_RESET;
        end else begin
            irq_out <= any_pending ? irq_level : ~irq_level;
        end
    end

    // Reserved map codes fall back to the default map
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            led_out <= 2'h0;
        end else if (indicator_map_select == LED_MAP_ACTIVITY) begin
            led_out <= {activity_ind_in, link_ind_in};
        end else begin
            led_out <= {speed_ind_in, link_ind_in & activity_ind_in};
        end
    end

    assign remote_loopback_out            = remote_loop;
    assign crossover_algorithm_select_out = crossover_algorithm_select;
    assign auto_crossover_en_out          = ~swap_disable;
    assign pair_crossed_out  = swap_disable ? manual_crossed : line_sync[0];
    assign tx_on_rx_pair_out = pair_crossed_out;

    // Read of the event register with no new event in the same cycle
    sequence s_quiet_event_read;
        rd_event && !(|evt_rise);
    endsequence

    property p_status_clear;
        @(posedge clk_in) disable iff (rst_in)
        s_quiet_event_read |=> evt_status == '0;
    endproperty
    a_status_clear: assert property (p_status_clear) else $error("status not cleared");

    property p_status_set;
        @(posedge clk_in) disable iff (rst_in)
        (|evt_rise) |=> (evt_status & $past(evt_rise)) == $past(evt_rise);
    endproperty
    a_status_set: assert property (p_status_set) else $error("event lost");

    property p_irq_level;
        @(posedge clk_in) disable iff (rst_in)
        any_pending |=> irq_out == $past(irq_level);
    endproperty
    a_irq_level: assert property (p_irq_level) else $error("irq wrong level");

    property p_irq_idle;
        @(posedge clk_in) disable iff (rst_in)
        !any_pending |=> irq_out != $past(irq_level);
    endproperty
    a_irq_idle: assert property (p_irq_idle) else $error("irq not idle");

    property p_enable_write;
        @(posedge clk_in) disable iff (rst_in)
        reg_wr_in && hit(reg_addr_in, ADDR_EVENT_IRQ)
            |=> evt_enable == $past(reg_wdata_in[EVT_ENABLE_LSB +: NEVT]);
    endproperty
    a_enable_write: assert property (p_enable_write) else $error("enable not written");

    property p_manual;
        @(posedge clk_in) disable iff (rst_in)
        swap_disable |-> pair_crossed_out == manual_crossed;
    endproperty
    a_manual: assert property (p_manual) else $error("manual pair ignored");

    property p_auto;
        @(posedge clk_in) disable iff (rst_in)
        !swap_disable |-> pair_crossed_out == line_sync[0];
    endproperty
    a_auto: assert property (p_auto) else $error("auto pair ignored");

    property p_reserved;
        @(posedge clk_in) disable iff (rst_in)
        reg_rd_in && hit(reg_addr_in, ADDR_LED_LINE)
            |=> reg_rdata_out[12] == 1'b0 && reg_rdata_out[6:0] == 7'h00;
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved bits nonzero");

    property p_readback_loop;
        @(posedge clk_in) disable iff (rst_in)
        reg_rd_in && hit(reg_addr_in, ADDR_LED_LINE)
            |=> reg_rdata_out[REMOTE_LOOP_BIT] == remote_loopback_out;
    endproperty
    a_readback_loop: assert property (p_readback_loop) else $error("loopback readback");
endmodule : phyirq_regs
`default_nettype wire

/* bench/phyirq_host.sv */
`timescale 1ns/1ps
`default_nettype none
module phyirq_host
    import phyirq_pkg::*;
(
    input  wire logic              clk_in,
    output var  logic [REG_AW-1:0] addr_out,
    output var  logic              wr_out,
    output var  logic              rd_out,
    output var  logic [REG_DW-1:0] wdata_out,
    input  wire logic [REG_DW-1:0] rdata_in
);
    initial begin
        addr_out  = 5'h00;
        wr_out    = 1'b0;
        rd_out    = 1'b0;
        wdata_out = 16'h0000;
    end

    task automatic wr(input logic [REG_AW-1:0] a, input logic [REG_DW-1:0] d);
        @(negedge clk_in);
        addr_out  = a;
        // Reserved indicator codes are never sent
        wdata_out = (a == ADDR_LED_LINE) ? {1'b0, d[REG_DW-2:0]} : d;
        wr_out    = 1'b1;
        @(negedge clk_in);
        wr_out = 1'b0;
    endtask : wr

    task automatic rd(input logic [REG_AW-1:0] a, output logic [REG_DW-1:0] d);
        @(negedge clk_in);
        addr_out = a;
        rd_out   = 1'b1;
        @(negedge clk_in);
        rd_out = 1'b0;
        d      = rdata_in;
    endtask : rd
endmodule : phyirq_host
`default_nettype wire

/* bench/phy_interrupt_and_control_regs_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin errors++; \
    $display("ERROR t=%0t got=%h exp=%h", $time, (g), (e)); end end
module phy_interrupt_and_control_regs_tb
    import phyirq_pkg::*;
;
    logic              clk = 1'b0;
    logic              rst = 1'b1;
    logic [REG_AW-1:0] addr;
    logic              wr;
    logic              rd;
    logic [REG_DW-1:0] wdata;
    logic [REG_DW-1:0] rdata;
    logic [REG_DW-1:0] d;
    logic [7:0]        evt = 8'h00;
    logic              pol = 1'b0;
    logic              apc = 1'b0;
    logic              spd = 1'b1;
    logic              lnk = 1'b1;
    logic              act = 1'b0;
    logic              irq;
    logic [1:0]        led;
    logic              loopb;
    logic              xalg;
    logic              auto_en;
    logic              crossed;
    logic              txrx;
    int                errors = 0;
    int                check_count = 0;

    initial forever #25 clk = ~clk;

    phyirq_host i_phyirq_host (.clk_in(clk), .addr_out(addr), .wr_out(wr), .rd_out(rd),
        .wdata_out(wdata), .rdata_in(rdata));

    phyirq_regs i_phyirq_regs (.clk_in(clk), .rst_in(rst), .reg_addr_in(addr),
        .reg_wr_in(wr), .reg_rd_in(rd), .reg_wdata_in(wdata), .reg_rdata_out(rdata),
        .event_pulse_in(evt), .polarity_reversed_in(pol), .auto_pair_crossed_in(apc),
        .speed_ind_in(spd), .link_ind_in(lnk), .activity_ind_in(act), .irq_out(irq),
        .led_out(led), .remote_loopback_out(loopb), .crossover_algorithm_select_out(xalg),
        .auto_crossover_en_out(auto_en), .pair_crossed_out(crossed), .tx_on_rx_pair_out(txrx));

    task automatic print_verdict;
        $display("Comparisons %0d, mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : print_verdict

    task automatic t_reset;
        i_phyirq_host.rd(ADDR_EVENT_IRQ, d); `CHK(d, 16'h0000)
        `CHK(irq, 1'b1)
        i_phyirq_host.rd(ADDR_LED_LINE, d); `CHK(d, 16'h0000)
        i_phyirq_host.rd(ADDR_CROSSOVER, d); `CHK(d, 16'h8000)
        `CHK({xalg, auto_en, loopb, crossed}, 4'hC)
    endtask : t_reset

    task automatic t_events;
        i_phyirq_host.wr(ADDR_EVENT_IRQ, 16'hA5FF);
        i_phyirq_host.rd(ADDR_EVENT_IRQ, d); `CHK(d, 16'hA500)
        i_phyirq_host.wr(ADDR_EVENT_IRQ, 16'h0100);
        @(negedge clk) evt = 8'h80;
        repeat (8) @(negedge clk);
        `CHK(irq, 1'b1)
        evt = 8'h81;
        repeat (8) @(negedge clk);
        `CHK(irq, 1'b0)
        evt = 8'h00;
        i_phyirq_host.rd(ADDR_EVENT_IRQ, d); `CHK(d, 16'h0181)
        i_phyirq_host.rd(ADDR_EVENT_IRQ, d); `CHK(d, 16'h0100)
        repeat (2) @(negedge clk);
        `CHK(irq, 1'b1)
    endtask : t_events

    task automatic t_level;
        i_phyirq_host.wr(ADDR_CROSSOVER, 16'h0200);
        repeat (3) @(negedge clk);
        `CHK(irq, 1'b0)
        `CHK(xalg, 1'b0)
        // Enabled link-up event must now drive the pin high
        evt = 8'h01;
        repeat (8) @(negedge clk);
        `CHK(irq, 1'b1)
        evt = 8'h00;
        i_phyirq_host.rd(ADDR_EVENT_IRQ, d); `CHK(d, 16'h0101)
        repeat (2) @(negedge clk);
        `CHK(irq, 1'b0)
    endtask : t_level

    task automatic t_led;
        @(negedge clk) pol = 1'b1;
        i_phyirq_host.wr(ADDR_LED_LINE, 16'h7FFF);
        repeat (4) @(negedge clk);
        i_phyirq_host.rd(ADDR_LED_LINE, d); `CHK(d, 16'h6080)
        `CHK(led, 2'b01)
        `CHK(loopb, 1'b1)
        i_phyirq_host.wr(ADDR_LED_LINE, 16'h0000);
        act = 1'b1;
        repeat (2) @(negedge clk);
        `CHK(led, 2'b11)
        `CHK(loopb, 1'b0)
        spd = 1'b0;
        repeat (2) @(negedge clk);
        `CHK(led, 2'b01)
        i_phyirq_host.rd(ADDR_LED_LINE, d); `CHK(d, 16'h2000)
    endtask : t_led

    task automatic t_cross;
        i_phyirq_host.wr(ADDR_CROSSOVER, 16'h6000);
        @(negedge clk);
        `CHK({auto_en, crossed, txrx}, 3'b011)
        i_phyirq_host.wr(ADDR_CROSSOVER, 16'h2000);
        @(negedge clk);
        `CHK({auto_en, crossed, txrx}, 3'b000)
        i_phyirq_host.wr(ADDR_CROSSOVER, 16'h5FFF);
        @(negedge clk);
        `CHK({auto_en, crossed}, 2'b10)
        i_phyirq_host.rd(ADDR_CROSSOVER, d); `CHK(d, 16'h4200)
        i_phyirq_host.rd(5'h00, d); `CHK(d, 16'h0000)
        // Automatic detection reports a crossed cable
        apc = 1'b1;
        repeat (3) @(negedge clk);
        `CHK({crossed, txrx}, 2'b11)
        i_phyirq_host.rd(ADDR_LED_LINE, d); `CHK(d, 16'h2800)
    endtask : t_cross

    initial begin
        repeat (6) @(negedge clk);
        rst = 1'b0;
        t_reset();
        t_events();
        t_level();
        t_led();
        t_cross();
        print_verdict();
    end

    initial begin
        repeat (3000) @(posedge clk);
        errors++;
        print_verdict();
    end
endmodule : phy_interrupt_and_control_regs_tb
`default_nettype wire
